// File: thc_monitor.sv
// Two-hand control monitor: evaluates one push-button pair with one or two contacts per button,
// drives the safe enable, fault and diagnostic outputs, holds registers.
// Assumes inputs synchronous to ref_clk and a one-cycle strobe register port.
`timescale 1ns/10ps
`include "thc_defines.svh"
module thc_monitor #(
    parameter int WINDOW_CYCLES = `THC_WINDOW_CYCLES,
    parameter int SCAN_CYCLES = `THC_SCAN_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Button contacts
    input wire logic channel_in_1,
    input wire logic channel_in_2,
    input wire logic channel_in_3,
    input wire logic channel_in_4,
    input wire logic block_enable_in,
    // Monitor outputs
    output logic safe_enable_out,
    output logic fault_out,
    output logic [31:0] diag_code_out,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Interrupt
    output logic irq
);

    // ============================================================
    // Declarations
    thc_pkg::thc_inputs_t in_now;
    thc_pkg::thc_inputs_t in_r;
    thc_pkg::thc_inputs_t in_nxt;
    thc_pkg::thc_inputs_t snap_r;
    thc_pkg::thc_inputs_t snap_nxt;
    thc_pkg::thc_state_t state_r;
    thc_pkg::thc_state_t state_nxt;
    logic [1:0] ctrl_r;
    logic [1:0] ctrl_nxt;
    logic [1:0] ctrl_prev_r;
    logic [`THC_IRQ_WIDTH-1:0] irq_stat_r;
    logic [`THC_IRQ_WIDTH-1:0] irq_stat_nxt;
    logic [`THC_IRQ_WIDTH-1:0] irq_mask_r;
    logic [`THC_IRQ_WIDTH-1:0] irq_mask_nxt;
    logic [`THC_IRQ_WIDTH-1:0] irq_event;
    logic [15:0] fault_code_r;
    logic [15:0] fault_code_nxt;
    logic [15:0] diag_nxt;
    logic [31:0] diag_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic qs_r;
    logic qs_nxt;
    logic er_r;
    logic er_nxt;
    logic tick;
    logic expired;
    logic win_start;
    logic dual;
    logic ext_req;
    logic allowed;
    logic actuated;
    logic released;
    logic btn1_undef;
    logic btn2_undef;
    logic changed;

    assign in_now = '{ch4: channel_in_4, ch3: channel_in_3, ch2: channel_in_2, ch1: channel_in_1};

    // ============================================================
    // Helpers
    thc_scan_tick #(
        .SCAN_CYCLES(SCAN_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick)
    );

    assign win_start = tick && (state_r == thc_pkg::THC_RELEASED) && !released;

    thc_window_timer #(
        .WINDOW_CYCLES(WINDOW_CYCLES)
    ) u_window (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(win_start),
        .run(state_r == thc_pkg::THC_ARMING),
        .expired(expired)
    );

    // ============================================================
    // Contact evaluation
    // evaluation mode select
    assign dual = ctrl_r[`THC_CTRL_DUAL_BIT];
    assign ext_req = ctrl_r[`THC_CTRL_EXT_EN_BIT];
    assign allowed = !ext_req || block_enable_in;

    always_comb
    begin
        actuated = 1'b0;
        released = 1'b0;
        btn1_undef = 1'b0;
        btn2_undef = 1'b0;
        if (dual)
        begin
            actuated = in_r.ch1 && in_r.ch3 && !in_r.ch2 && !in_r.ch4;
            released = !in_r.ch1 && !in_r.ch3 && in_r.ch2 && in_r.ch4;
            btn1_undef = (in_r.ch1 == in_r.ch2);
            btn2_undef = (in_r.ch3 == in_r.ch4);
        end
        else
        begin
            actuated = in_r.ch1 && in_r.ch2;
            released = !in_r.ch1 && !in_r.ch2;
        end
    end

    // any edge on a used contact
    assign changed = dual ? (in_r != snap_r) : (in_r.ch2 != snap_r.ch2 || in_r.ch1 != snap_r.ch1);

    // ============================================================
    // Monitor state machine, judged once per scan
    always_comb
    begin
        state_nxt = state_r;
        snap_nxt = snap_r;
        fault_code_nxt = fault_code_r;
        in_nxt = tick ? in_now : in_r;
        // Restart through DISABLED: start-up must judge a sample taken under the new mode
        if (!allowed || ctrl_r != ctrl_prev_r)
        begin
            state_nxt = thc_pkg::THC_DISABLED;
        end
        else if (tick)
        begin
            case (state_r)
                thc_pkg::THC_DISABLED:
                begin
                    state_nxt = thc_pkg::THC_STARTUP;
                end
                thc_pkg::THC_STARTUP:
                begin
                    if (!released)
                    begin
                        state_nxt = thc_pkg::THC_FAULT;
                        fault_code_nxt = `THC_DG_ERR_STARTUP;
                    end
                    else
                    begin
                        state_nxt = thc_pkg::THC_RELEASED;
                    end
                end
                thc_pkg::THC_RELEASED:
                begin
                    if (!released)
                    begin
                        state_nxt = thc_pkg::THC_ARMING;
                    end
                end
                thc_pkg::THC_ARMING:
                begin
                    if (actuated && !expired)
                    begin
                        state_nxt = thc_pkg::THC_ACTIVE;
                        snap_nxt = in_r;
                    end
                    else if (expired)
                    begin
                        state_nxt = thc_pkg::THC_FAULT;
                        fault_code_nxt = `THC_DG_ERR_LATE;
                    end
                    else if (released && dual)
                    begin
                        state_nxt = thc_pkg::THC_FAULT;
                        fault_code_nxt = `THC_DG_ERR_ONE_CH;
                    end
                    else if (released)
                    begin
                        state_nxt = thc_pkg::THC_RELEASED;
                    end
                end
                thc_pkg::THC_ACTIVE:
                begin
                    if (changed)
                    begin
                        state_nxt = thc_pkg::THC_WAIT_RELEASE;
                    end
                end
                thc_pkg::THC_WAIT_RELEASE:
                begin
                    if (released)
                    begin
                        state_nxt = thc_pkg::THC_RELEASED;
                    end
                end
                thc_pkg::THC_FAULT:
                begin
                    if (released)
                    begin
                        state_nxt = thc_pkg::THC_RELEASED;
                    end
                end
                default:
                begin
                    state_nxt = thc_pkg::THC_DISABLED;
                end
            endcase
        end
    end

    // ============================================================
    // Outputs and diagnostics
    always_comb
    begin
        er_nxt = (state_nxt == thc_pkg::THC_FAULT);
        qs_nxt = (state_nxt == thc_pkg::THC_ACTIVE);
        case (state_nxt)
            thc_pkg::THC_DISABLED: diag_nxt = `THC_DG_NO_ENABLE;
            thc_pkg::THC_STARTUP: diag_nxt = `THC_DG_WAIT_FIRST;
            thc_pkg::THC_RELEASED: diag_nxt = `THC_DG_NORMAL_POS;
            thc_pkg::THC_ARMING:
            begin
                if (btn1_undef)
                begin
                    diag_nxt = `THC_DG_BTN1_UNDEF;
                end
                else if (btn2_undef)
                begin
                    diag_nxt = `THC_DG_BTN2_UNDEF;
                end
                else
                begin
                    diag_nxt = `THC_DG_WAIT_FIRST;
                end
            end
            thc_pkg::THC_ACTIVE: diag_nxt = `THC_DG_OPERATED;
            thc_pkg::THC_WAIT_RELEASE: diag_nxt = `THC_DG_ONE_CHANNEL;
            thc_pkg::THC_FAULT: diag_nxt = fault_code_nxt;
            default: diag_nxt = `THC_DG_NO_ENABLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_r <= thc_pkg::THC_DISABLED;
            in_r <= '0;
            snap_r <= '0;
            fault_code_r <= `THC_DG_NO_ENABLE;
            qs_r <= 1'b0;
            er_r <= 1'b0;
            diag_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            in_r <= in_nxt;
            snap_r <= snap_nxt;
            fault_code_r <= fault_code_nxt;
            qs_r <= qs_nxt;
            er_r <= er_nxt;
            diag_r <= {16'h0000, diag_nxt};
        end
    end

    assign safe_enable_out = qs_r;
    assign fault_out = er_r;
    assign diag_code_out = diag_r;

    // ============================================================
    // Registers and interrupt
    assign irq_event[`THC_IRQ_CLOSE_BIT] = qs_nxt && !qs_r;
    assign irq_event[`THC_IRQ_OPEN_BIT] = !qs_nxt && qs_r;
    assign irq_event[`THC_IRQ_FAULT_BIT] = er_nxt && !er_r;

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        irq_mask_nxt = irq_mask_r;
        irq_stat_nxt = irq_stat_r;
        rdata_nxt = '0;
        if (reg_wr)
        begin
            case (reg_addr)
                `THC_OFS_CTRL: ctrl_nxt = reg_wdata[1:0];
                `THC_OFS_IRQ_MASK: irq_mask_nxt = reg_wdata[`THC_IRQ_WIDTH-1:0];
                `THC_OFS_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~reg_wdata[`THC_IRQ_WIDTH-1:0];
                default: ctrl_nxt = ctrl_r;
            endcase
        end
        // New events win over a same-cycle clear
        irq_stat_nxt = irq_stat_nxt | irq_event;
        if (reg_rd)
        begin
            case (reg_addr)
                `THC_OFS_CTRL: rdata_nxt = {30'h0, ctrl_r};
                `THC_OFS_STATUS: rdata_nxt = {24'h0, in_r, 2'h0, er_r, qs_r};
                `THC_OFS_DIAG: rdata_nxt = diag_r;
                `THC_OFS_IRQ_STAT: rdata_nxt = {29'h0, irq_stat_r};
                `THC_OFS_IRQ_MASK: rdata_nxt = {29'h0, irq_mask_r};
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctrl_r <= `THC_CTRL_RESET;
            ctrl_prev_r <= `THC_CTRL_RESET;
            irq_mask_r <= `THC_IRQ_MASK_RESET;
            irq_stat_r <= '0;
            rdata_r <= '0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            ctrl_prev_r <= ctrl_r;
            irq_mask_r <= irq_mask_nxt;
            irq_stat_r <= irq_stat_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign irq = |(irq_stat_r & irq_mask_r);

endmodule : thc_monitor

// File: thc_defines.svh
// Constants of the two-hand control monitor: register map, fields,
// reset values, diagnostic codes and timing.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef THC_DEFINES_SVH
`define THC_DEFINES_SVH

// ============================================================
// Register offsets (byte addresses)
`define THC_OFS_CTRL 8'h00
`define THC_OFS_STATUS 8'h04
`define THC_OFS_DIAG 8'h08
`define THC_OFS_IRQ_STAT 8'h0C
`define THC_OFS_IRQ_MASK 8'h10

// ============================================================
// Field positions
`define THC_CTRL_DUAL_BIT 0
`define THC_CTRL_EXT_EN_BIT 1
`define THC_IRQ_CLOSE_BIT 0
`define THC_IRQ_OPEN_BIT 1
`define THC_IRQ_FAULT_BIT 2
`define THC_IRQ_WIDTH 3
`define THC_ST_ENABLE_BIT 0
`define THC_ST_FAULT_BIT 1
`define THC_ST_INPUT_LSB 4

// ============================================================
// Reset values: dual-channel evaluation, no external enable
`define THC_CTRL_RESET 2'h1
`define THC_IRQ_MASK_RESET 3'h0

// ============================================================
// Diagnostic codes
`define THC_DG_NO_ENABLE 16'h0000
`define THC_DG_WAIT_FIRST 16'h2001
`define THC_DG_ONE_CHANNEL 16'h2005
`define THC_DG_NORMAL_POS 16'h2016
`define THC_DG_BTN1_UNDEF 16'h2017
`define THC_DG_BTN2_UNDEF 16'h2018
`define THC_DG_OPERATED 16'h800B
`define THC_DG_ERR_LATE 16'hF006
`define THC_DG_ERR_ONE_CH 16'hF00E
`define THC_DG_ERR_STARTUP 16'hF018

// ============================================================
// Timing
`define THC_WINDOW_MS 500
`define THC_CLK_HZ 100000000
`define THC_WINDOW_CYCLES ((`THC_CLK_HZ / 1000) * `THC_WINDOW_MS)
`define THC_SCAN_CYCLES 1000

`endif

// File: thc_pkg.sv
// Types shared by the two-hand control monitor files.
// Assumes thc_defines.svh holds all numeric constants.
package thc_pkg;

    // ============================================================
    // Sampled contact inputs
    typedef struct packed {
        logic ch4;
        logic ch3;
        logic ch2;
        logic ch1;
    } thc_inputs_t;

    // ============================================================
    // Monitor states
    typedef enum logic [2:0] {
        THC_DISABLED,
        THC_STARTUP,
        THC_RELEASED,
        THC_ARMING,
        THC_ACTIVE,
        THC_WAIT_RELEASE,
        THC_FAULT
    } thc_state_t;

endpackage : thc_pkg

// File: thc_scan_tick.sv
// Scan-cycle tick generator for the two-hand control monitor.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/10ps
`include "thc_defines.svh"
module thc_scan_tick #(
    parameter int SCAN_CYCLES = `THC_SCAN_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Tick
    output logic tick
);

    localparam int CW = $clog2(SCAN_CYCLES + 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb
    begin
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CW'(SCAN_CYCLES - 1))
        begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule : thc_scan_tick

// File: thc_window_timer.sv
// Synchronisation window timer: restarts on start, flags expiry.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/10ps
`include "thc_defines.svh"
module thc_window_timer #(
    parameter int WINDOW_CYCLES = `THC_WINDOW_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic run,
    // Result
    output logic expired
);

    localparam int CW = $clog2(WINDOW_CYCLES + 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic exp_r;
    logic exp_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        exp_nxt = exp_r;
        if (start || !run)
        begin
            cnt_nxt = '0;
            exp_nxt = 1'b0;
        end
        else if (cnt_r == CW'(WINDOW_CYCLES - 1))
        begin
            exp_nxt = 1'b1;
        end
        else
        begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign expired = exp_r;

endmodule : thc_window_timer

// File: thc_checker.sv
// Port checks for the two-hand control monitor.
// Assumes binding onto thc_monitor, with its two count parameters handed on.
`timescale 1ns/10ps
`include "thc_defines.svh"
module thc_checker #(
    parameter int WINDOW_CYCLES = 200,
    parameter int SCAN_CYCLES = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Contacts
    input wire logic channel_in_1,
    input wire logic channel_in_2,
    input wire logic channel_in_3,
    input wire logic channel_in_4,
    input wire logic block_enable_in,
    // Monitor outputs
    input wire logic safe_enable_out,
    input wire logic fault_out,
    input wire logic [31:0] diag_code_out,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq
);
    // Wait for a tick, judged one tick later, small margin
    localparam int DROP_MAX = 2 * SCAN_CYCLES + 3;
    logic [3:0] ins;
    logic [3:0] ins_r;
    logic [31:0] quiet_r;
    logic [31:0] quiet_nxt;

    assign ins = {channel_in_4, channel_in_3, channel_in_2, channel_in_1};

    // ====================
    // Cycles since the contacts last moved
    always_comb
    begin
        quiet_nxt = quiet_r;
        if (rst || ins != ins_r)
            quiet_nxt = 32'h0;
        else if (quiet_r != 32'hFFFFFFFF)
            quiet_nxt = quiet_r + 32'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        ins_r <= ins;
        quiet_r <= quiet_nxt;
    end

    // ====================
    // Properties
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_ins_moved;
        ins != $past(ins);
    endsequence
    sequence s_enable_gone;
        ##[1:DROP_MAX] !safe_enable_out;
    endsequence
    sequence s_late_fault;
        $rose(fault_out) ##0 diag_code_out[15:0] == `THC_DG_ERR_LATE;
    endsequence

    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    AST_DIAG_UPPER: assert property (diag_code_out[31:16] == 16'h0000)
        else $error("diag upper half not zero");
    AST_ENABLE_CODE: assert property (safe_enable_out |-> diag_code_out[15:0] == `THC_DG_OPERATED)
        else $error("enable closed without operated code");
    AST_ENABLE_NO_FAULT: assert property (safe_enable_out |-> !fault_out)
        else $error("enable closed during a fault");
    AST_FAULT_CODE: assert property (fault_out |-> diag_code_out[15:12] == 4'hF)
        else $error("fault without an error code");
    AST_DROP_ON_CHANGE: assert property (s_ins_moved ##0 safe_enable_out |-> s_enable_gone)
        else $error("enable kept after a contact moved");
    AST_CLOSE_NEEDS_PRESS: assert property ($rose(safe_enable_out) |-> channel_in_1 && !$past(fault_out))
        else $error("enable closed without a press");
    AST_FAULT_CLEAR: assert property ($fell(fault_out) |-> (!channel_in_1 && !channel_in_3) || !block_enable_in)
        else $error("fault cleared without release");
    AST_NO_EARLY_FAULT: assert property (s_late_fault |-> quiet_r >= WINDOW_CYCLES - 1)
        else $error("late press fault before the window ended");
endmodule : thc_checker

bind thc_monitor thc_checker #(
    .WINDOW_CYCLES(WINDOW_CYCLES),
    .SCAN_CYCLES(SCAN_CYCLES)
) u_checker (
    .ref_clk(ref_clk), .rst(rst),
    .channel_in_1(channel_in_1), .channel_in_2(channel_in_2),
    .channel_in_3(channel_in_3), .channel_in_4(channel_in_4),
    .block_enable_in(block_enable_in), .safe_enable_out(safe_enable_out),
    .fault_out(fault_out), .diag_code_out(diag_code_out),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
);

// File: thc_buttons.sv
// Two-hand push-button station model driving the four contacts.
// Assumes press commands from the bench, changed just after a clock edge.
`timescale 1ns/10ps
module thc_buttons (
    // Clock
    input wire logic ref_clk,
    // Operator side
    input wire logic dual_mode,
    input wire logic press_1,
    input wire logic press_2,
    // Contacts
    output logic channel_in_1,
    output logic channel_in_2,
    output logic channel_in_3,
    output logic channel_in_4
);
    // Start released in the default two-channel wiring
    initial
    begin
        channel_in_1 = 1'h0;
        channel_in_2 = 1'h1;
        channel_in_3 = 1'h0;
        channel_in_4 = 1'h1;
    end

    // Make/break pairs, or two makes with contacts 3 and 4 unwired
    always @(posedge ref_clk)
    begin
        channel_in_1 <= press_1;
        channel_in_2 <= dual_mode ? ~press_1 : press_2;
        channel_in_3 <= dual_mode & press_2;
        channel_in_4 <= dual_mode & ~press_2;
    end
endmodule : thc_buttons

// File: tb.sv
// Self-checking bench for the two-hand control monitor.
// Assumes the station model and the bound port checker.
`timescale 1ns/10ps
`include "thc_defines.svh"
module tb;
    // Short counts keep the run small
    localparam int WIN = 200;
    localparam int SCAN = 4;
    localparam int LIMIT = 5000;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic dual_mode = 1'h1;
    logic press_1 = 1'h0;
    logic press_2 = 1'h0;
    logic block_enable_in = 1'h1;
    logic seen_one_ch = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic c1, c2, c3, c4, safe_enable_out, fault_out, irq;
    logic [31:0] diag_code_out;
    logic [31:0] reg_rdata;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    thc_buttons u_buttons (.ref_clk(ref_clk), .dual_mode(dual_mode), .press_1(press_1), .press_2(press_2),
        .channel_in_1(c1), .channel_in_2(c2), .channel_in_3(c3), .channel_in_4(c4));
    thc_monitor #(.WINDOW_CYCLES(WIN), .SCAN_CYCLES(SCAN)) dut (.ref_clk(ref_clk), .rst(rst),
        .channel_in_1(c1), .channel_in_2(c2), .channel_in_3(c3), .channel_in_4(c4),
        .block_enable_in(block_enable_in), .safe_enable_out(safe_enable_out), .fault_out(fault_out),
        .diag_code_out(diag_code_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end

    // ====================
    // Tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle

    // Mode follows a control write at the same edge, so no false pattern is seen
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        if (a == `THC_OFS_CTRL)
            dual_mode <= d[0];
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask : reg_write

    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1;
        check(what, exp, reg_rdata);
    endtask : reg_check

    task automatic push(input logic b1, input logic b2, input int n);
        @(posedge ref_clk);
        press_1 <= b1;
        press_2 <= b2;
        settle(n);
    endtask : push

    task automatic expect_out(input logic en, input logic flt, input logic [15:0] code);
        check("safe enable", {31'h0, en}, {31'h0, safe_enable_out});
        check("fault", {31'h0, flt}, {31'h0, fault_out});
        check("diag code", {16'h0000, code}, diag_code_out);
    endtask : expect_out

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        // One-channel fault stands only one scan
        if (diag_code_out[15:0] == `THC_DG_ERR_ONE_CH)
        begin
            seen_one_ch <= 1'h1;
        end
        if (cycles == LIMIT)
        begin
            miscompares++;
            final_report();
        end
    end

    // ====================
    // Sequence
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        settle(1);
        expect_out(1'h0, 1'h0, `THC_DG_NO_ENABLE);
        settle(24);
        expect_out(1'h0, 1'h0, `THC_DG_NORMAL_POS);
        reg_check(`THC_OFS_CTRL, 32'h1, "ctrl");
        reg_check(`THC_OFS_IRQ_MASK, 32'h0, "mask");
        reg_check(8'h20, 32'h0, "unmapped");
        reg_write(`THC_OFS_DIAG, 32'h0000FFFF);
        reg_check(`THC_OFS_DIAG, {16'h0000, `THC_DG_NORMAL_POS}, "diag read only");
        push(1'h1, 1'h1, 24);
        expect_out(1'h1, 1'h0, `THC_DG_OPERATED);
        reg_check(`THC_OFS_IRQ_STAT, 32'h1, "irq stat close");
        check("irq masked", 32'h0, {31'h0, irq});
        reg_write(`THC_OFS_IRQ_MASK, 32'h7);
        settle(2);
        check("irq raised", 32'h1, {31'h0, irq});
        reg_write(`THC_OFS_IRQ_STAT, 32'h1);
        settle(2);
        check("irq cleared", 32'h0, {31'h0, irq});
        push(1'h0, 1'h1, 24);
        expect_out(1'h0, 1'h0, `THC_DG_ONE_CHANNEL);
        reg_check(`THC_OFS_IRQ_STAT, 32'h2, "irq stat open");
        push(1'h1, 1'h1, 24);
        expect_out(1'h0, 1'h0, `THC_DG_ONE_CHANNEL);
        push(1'h0, 1'h0, 24);
        expect_out(1'h0, 1'h0, `THC_DG_NORMAL_POS);
        // Second button slow but inside the window
        push(1'h1, 1'h0, WIN / 2);
        expect_out(1'h0, 1'h0, `THC_DG_WAIT_FIRST);
        push(1'h1, 1'h1, 24);
        expect_out(1'h1, 1'h0, `THC_DG_OPERATED);
        push(1'h0, 1'h0, 24);
        push(1'h1, 1'h0, WIN + 30);
        expect_out(1'h0, 1'h1, `THC_DG_ERR_LATE);
        reg_check(`THC_OFS_IRQ_STAT, 32'h7, "irq stat fault");
        check("irq fault", 32'h1, {31'h0, irq});
        reg_write(`THC_OFS_IRQ_STAT, 32'h7);
        push(1'h1, 1'h1, 24);
        expect_out(1'h0, 1'h1, `THC_DG_ERR_LATE);
        push(1'h0, 1'h0, 24);
        expect_out(1'h0, 1'h0, `THC_DG_NORMAL_POS);
        // One button pressed and let go inside the window
        push(1'h1, 1'h0, 24);
        push(1'h0, 1'h0, 24);
        check("one channel fault", 32'h1, {31'h0, seen_one_ch});
        reg_check(`THC_OFS_IRQ_STAT, 32'h4, "irq stat one channel");
        expect_out(1'h0, 1'h0, `THC_DG_NORMAL_POS);
        // Single-channel evaluation
        reg_write(`THC_OFS_CTRL, 32'h0);
        settle(24);
        expect_out(1'h0, 1'h0, `THC_DG_NORMAL_POS);
        push(1'h1, 1'h1, 24);
        expect_out(1'h1, 1'h0, `THC_DG_OPERATED);
        push(1'h0, 1'h0, 24);
        push(1'h0, 1'h1, WIN + 30);
        expect_out(1'h0, 1'h1, `THC_DG_ERR_LATE);
        push(1'h1, 1'h0, 24);
        expect_out(1'h0, 1'h1, `THC_DG_ERR_LATE);
        push(1'h0, 1'h0, 24);
        expect_out(1'h0, 1'h0, `THC_DG_NORMAL_POS);
        // External enable, then start-up with buttons held
        @(posedge ref_clk);
        block_enable_in <= 1'h0;
        reg_write(`THC_OFS_CTRL, 32'h3);
        settle(24);
        expect_out(1'h0, 1'h0, `THC_DG_NO_ENABLE);
        push(1'h1, 1'h1, 24);
        expect_out(1'h0, 1'h0, `THC_DG_NO_ENABLE);
        @(posedge ref_clk);
        block_enable_in <= 1'h1;
        settle(24);
        expect_out(1'h0, 1'h1, `THC_DG_ERR_STARTUP);
        push(1'h0, 1'h0, 24);
        expect_out(1'h0, 1'h0, `THC_DG_NORMAL_POS);
        final_report();
    end
endmodule : tb
